// file: logic/acs_pkg.sv
`default_nettype none
package acs_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL_A = 8'h00;
	localparam logic [7:0] OFF_CTRL_B = 8'h04;
	localparam logic [7:0] OFF_INSEL  = 8'h08;
	localparam logic [7:0] OFF_CTRL_C = 8'h0C;
	localparam logic [7:0] OFF_AVG    = 8'h10;
	localparam logic [7:0] OFF_SAMP   = 8'h14;
	localparam logic [7:0] OFF_WINDOW_LOWER_THRESHOLD  = 8'h18;
	localparam logic [7:0] OFF_WINDOW_UPPER_THRESHOLD  = 8'h1C;
	localparam logic [7:0] OFF_GAIN   = 8'h20;
	localparam logic [7:0] OFF_OFFS   = 8'h24;
	localparam logic [7:0] OFF_TRIG   = 8'h28;
	localparam logic [7:0] OFF_FLAG   = 8'h2C;
	localparam logic [7:0] OFF_BUSY   = 8'h30;
	localparam logic [7:0] OFF_RESULT = 8'h34;
	// Busy bit positions
	localparam int BSY_SOFT_RESET_BIT = 0;
	localparam int BSY_EN    = 1;
	localparam int BSY_INSEL = 2;
	localparam int BSY_CONTROL_THIRD_REG = 3;
	localparam int BSY_AVG   = 4;
	localparam int BSY_SAMP  = 5;
	localparam int BSY_WINDOW_LOWER_THRESHOLD = 6;
	localparam int BSY_WINDOW_UPPER_THRESHOLD = 7;
	localparam int BSY_GAIN  = 8;
	localparam int BSY_OFFS  = 9;
	localparam int BSY_TRIG  = 10;
	localparam int NUM_SYNC  = 11;
	// Field positions
	localparam int CA_SOFT_RESET_BIT   = 0;
	localparam int CA_EN      = 1;
	localparam int CC_DIFF    = 0;
	localparam int CC_FREE    = 2;
	localparam int CC_RES_LSB = 4;
	localparam int SC_OFFSET_COMP_ENABLE = 7;
	localparam int TR_START   = 1;
	localparam int FL_RESULT_READY_FLAG  = 0;
	// Resolution codes
	localparam logic [1:0] RES_12 = 2'h0;
	localparam logic [1:0] RES_10 = 2'h2;
	localparam logic [1:0] RES_8  = 2'h3;
	// Write masks and reset values
	localparam logic [7:0]  CONTROL_THIRD_REG_MASK  = 8'h35;
	localparam logic [7:0]  SAMP_MASK   = 8'hBF;
	localparam logic [7:0]  AVG_MASK    = 8'h7F;
	localparam logic [15:0] INSEL_MASK  = 16'h1F1F;
	localparam logic [7:0]  CONTROL_THIRD_REG_RST   = 8'h00;
	localparam logic [7:0]  SAMP_RST    = 8'h00;
	// Cycle counts
	localparam int SYNC_DEF    = 3;
	localparam int OFFSET_COMP_ENABLE_DEF = 4;
	// Conversion states
	typedef enum logic [3:0] {
		ACS_IDLE    = 4'b0001,
		ACS_SAMPLE  = 4'b0010,
		ACS_OFFSET_COMP_ENABLE = 4'b0100,
		ACS_CONV    = 4'b1000
	} acs_state_t;
endpackage
`default_nettype wire

// file: logic/acs_adc_sequencer.sv
// Functional notes
// - Resolution 8, 10 or 12 bits by resolution_select; reset gives 12.
// - differential_enable set gives differential conversion, clear single-ended.
// - Single and free-running modes; free-run restarts without new trigger.
// - result_ready_flag sets at the end of every conversion.
// - Conversion starts only after trigger is synchronized into converter domain.
// - Default sampling occupies first half of one converter clock period.
// - sample_length_field nonzero gives that value plus one whole converter clock cycles of sampling.
// - Offset compensation enable bit; sampling then forced to the default half period.
// - Free-run period is sampling plus compensation plus resolution cycles.
// - Converter clock is generic clock divided by two to one plus prescaler.
// - Busy bits set when a crossing write starts, clear at completion.
// - Busy bit 10 follows soft trigger register.
// - Busy bit 9 follows offset correction register.
// - Busy bit 8 follows gain correction register.
// - Busy bit 7 follows window upper threshold register.
// - Busy bit 6 follows window lower threshold register.
// - Busy bit 5 follows sampling control register.
// - Busy bit 4 follows averaging control register.
// - Busy bit 3 follows third control register.
`default_nettype none
module acs_adc_sequencer #(
	parameter int OFFSET_COMP_ENABLE_CYCLES = acs_pkg::OFFSET_COMP_ENABLE_DEF,
	parameter int SYNC_CYCLES    = acs_pkg::SYNC_DEF
) (
	// Clock, reset and enable
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Converter side
	input  wire logic        event_start_i,
	input  wire logic        comp_i,
	output logic             adc_clk_o,
	output logic             sample_o,
	output logic             diff_o,
	output logic      [11:0] dac_o,
	output logic      [4:0]  pos_sel_o,
	output logic      [4:0]  neg_sel_o,
	output logic             conv_done_o
);

	// Elaboration checks
	if (OFFSET_COMP_ENABLE_CYCLES < 1 || OFFSET_COMP_ENABLE_CYCLES > 63) begin : g_bad_oc
		$error("OFFSET_COMP_ENABLE_CYCLES out of range 1..63");
	end
	if (SYNC_CYCLES < 1 || SYNC_CYCLES > 15) begin : g_bad_sy
		$error("SYNC_CYCLES out of range 1..15");
	end

	localparam logic [3:0] SYNC_LAST = 4'(SYNC_CYCLES - 1);
	localparam logic [5:0] OC_LAST   = 6'(OFFSET_COMP_ENABLE_CYCLES - 1);

	// Byte lane merge
	function automatic logic [31:0] acs_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] m;
		m = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				m[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// Bus side registers
	logic        soft_reset_bit_b;
	logic        en_b;
	logic [2:0]  presc_r;
	logic [15:0] insel_b;
	logic [7:0]  control_third_reg_b;
	logic [7:0]  avg_b;
	logic [7:0]  samp_b;
	logic [15:0] window_lower_threshold_b;
	logic [15:0] window_upper_threshold_b;
	logic [11:0] gain_b;
	logic [11:0] offs_b;
	logic        trig_pend_r;
	logic        flag_r;
	// Converter side copies
	logic        en_c;
	logic [7:0]  control_third_reg_c;
	logic [7:0]  samp_c;
	logic [15:0] insel_c;
	// Bus handshake
	logic        ack_r;
	logic [31:0] dat_r;
	logic        acc;
	logic        wr;
	logic [31:0] rd_v;
	logic [31:0] wv;
	// Crossing tracking
	logic [10:0] set_v;
	logic [10:0] sdone;
	logic [10:0] busy_v;
	logic        srst;
	// Synchronizers
	logic        evt_s1;
	logic        evt_s2;
	logic        evt_s3;
	logic        cmp_s1;
	logic        cmp_s2;
	// Conversion engine
	acs_pkg::acs_state_t state_r;
	logic [7:0]  div_r;
	logic [7:0]  div_nxt;
	logic [8:0]  div_top9;
	logic        tick;
	logic        first_half;
	logic [5:0]  cnt_r;
	logic [11:0] sar_r;
	logic [3:0]  bit_r;
	logic [11:0] res_r;
	logic        done_r;
	logic        sample_r;
	logic        adc_clk_r;
	logic        start_go;
	logic        trig_go;
	logic        evt_go;
	logic [3:0]  res_bits;
	logic [3:0]  low_bit;
	logic        offc;
	logic [5:0]  eff_len;
	logic [11:0] sar_dec;
	logic [11:0] sar_nx;

	assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr  = acc & wb_we_i;
	assign wv  = acs_merge(rd_v, wb_dat_i, wb_sel_i);

	// Read mux
	always_comb begin
		rd_v = 32'h0000_0000;
		if (wb_adr_i == acs_pkg::OFF_CTRL_A) begin
			rd_v[acs_pkg::CA_SOFT_RESET_BIT] = soft_reset_bit_b;
			rd_v[acs_pkg::CA_EN] = en_b;
		end else if (wb_adr_i == acs_pkg::OFF_CTRL_B) begin
			rd_v[2:0] = presc_r;
		end else if (wb_adr_i == acs_pkg::OFF_INSEL) begin
			rd_v[15:0] = insel_b;
		end else if (wb_adr_i == acs_pkg::OFF_CTRL_C) begin
			rd_v[7:0] = control_third_reg_b;
		end else if (wb_adr_i == acs_pkg::OFF_AVG) begin
			rd_v[7:0] = avg_b;
		end else if (wb_adr_i == acs_pkg::OFF_SAMP) begin
			rd_v[7:0] = samp_b;
		end else if (wb_adr_i == acs_pkg::OFF_WINDOW_LOWER_THRESHOLD) begin
			rd_v[15:0] = window_lower_threshold_b;
		end else if (wb_adr_i == acs_pkg::OFF_WINDOW_UPPER_THRESHOLD) begin
			rd_v[15:0] = window_upper_threshold_b;
		end else if (wb_adr_i == acs_pkg::OFF_GAIN) begin
			rd_v[11:0] = gain_b;
		end else if (wb_adr_i == acs_pkg::OFF_OFFS) begin
			rd_v[11:0] = offs_b;
		end else if (wb_adr_i == acs_pkg::OFF_FLAG) begin
			rd_v[acs_pkg::FL_RESULT_READY_FLAG] = flag_r;
		end else if (wb_adr_i == acs_pkg::OFF_BUSY) begin
			rd_v[10:0] = busy_v;
		end else if (wb_adr_i == acs_pkg::OFF_RESULT) begin
			rd_v[11:0] = res_r;
		end
	end

	// Crossing start per write
	always_comb begin
		set_v = 11'h000;
		if (wr) begin
			if (wb_adr_i == acs_pkg::OFF_CTRL_A) begin
				set_v[acs_pkg::BSY_EN] = 1'b1;
				set_v[acs_pkg::BSY_SOFT_RESET_BIT] = wv[acs_pkg::CA_SOFT_RESET_BIT];
			end else if (wb_adr_i == acs_pkg::OFF_INSEL) begin
				set_v[acs_pkg::BSY_INSEL] = 1'b1;
			end else if (wb_adr_i == acs_pkg::OFF_CTRL_C) begin
				set_v[acs_pkg::BSY_CONTROL_THIRD_REG] = 1'b1;
			end else if (wb_adr_i == acs_pkg::OFF_AVG) begin
				set_v[acs_pkg::BSY_AVG] = 1'b1;
			end else if (wb_adr_i == acs_pkg::OFF_SAMP) begin
				set_v[acs_pkg::BSY_SAMP] = 1'b1;
			end else if (wb_adr_i == acs_pkg::OFF_WINDOW_LOWER_THRESHOLD) begin
				set_v[acs_pkg::BSY_WINDOW_LOWER_THRESHOLD] = 1'b1;
			end else if (wb_adr_i == acs_pkg::OFF_WINDOW_UPPER_THRESHOLD) begin
				set_v[acs_pkg::BSY_WINDOW_UPPER_THRESHOLD] = 1'b1;
			end else if (wb_adr_i == acs_pkg::OFF_GAIN) begin
				set_v[acs_pkg::BSY_GAIN] = 1'b1;
			end else if (wb_adr_i == acs_pkg::OFF_OFFS) begin
				set_v[acs_pkg::BSY_OFFS] = 1'b1;
			end else if (wb_adr_i == acs_pkg::OFF_TRIG) begin
				set_v[acs_pkg::BSY_TRIG] = 1'b1;
			end
		end
	end

	// Busy bit per tracked register
	for (genvar gi = 0; gi < acs_pkg::NUM_SYNC; gi++) begin : g_sync
		logic       busy_r;
		logic [3:0] scnt_r;
		always_ff @(posedge mclk) begin
			if (!reset_n) begin
				busy_r <= 1'b0;
				scnt_r <= 4'h0;
			end else if (clk_en) begin
				if (set_v[gi]) begin
					busy_r <= 1'b1;
					scnt_r <= 4'h0;
				end else if (busy_r && scnt_r == SYNC_LAST) begin
					busy_r <= 1'b0;
				end else if (busy_r) begin
					scnt_r <= scnt_r + 4'h1;
				end
			end
		end
		assign busy_v[gi] = busy_r;
		assign sdone[gi]  = busy_r & (scnt_r == SYNC_LAST) & ~set_v[gi];
	end

	assign srst = sdone[acs_pkg::BSY_SOFT_RESET_BIT] & soft_reset_bit_b;

	// Bus handshake
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else if (clk_en) begin
			ack_r <= acc;
			if (acc) begin
				dat_r <= rd_v;
			end
		end
	end

	// Bus side register writes
	always_ff @(posedge mclk) begin
		if (!reset_n || srst) begin
			soft_reset_bit_b <= 1'b0;
			en_b    <= 1'b0;
			presc_r <= 3'h0;
			insel_b <= 16'h0000;
			control_third_reg_b <= acs_pkg::CONTROL_THIRD_REG_RST;
			avg_b   <= 8'h00;
			samp_b  <= acs_pkg::SAMP_RST;
			window_lower_threshold_b <= 16'h0000;
			window_upper_threshold_b <= 16'h0000;
			gain_b  <= 12'h000;
			offs_b  <= 12'h000;
		end else if (clk_en && wr) begin
			if (wb_adr_i == acs_pkg::OFF_CTRL_A) begin
				soft_reset_bit_b <= wv[acs_pkg::CA_SOFT_RESET_BIT];
				en_b <= wv[acs_pkg::CA_EN];
			end else if (wb_adr_i == acs_pkg::OFF_CTRL_B) begin
				presc_r <= wv[2:0];
			end else if (wb_adr_i == acs_pkg::OFF_INSEL) begin
				insel_b <= wv[15:0] & acs_pkg::INSEL_MASK;
			end else if (wb_adr_i == acs_pkg::OFF_CTRL_C) begin
				control_third_reg_b <= wv[7:0] & acs_pkg::CONTROL_THIRD_REG_MASK;
			end else if (wb_adr_i == acs_pkg::OFF_AVG) begin
				avg_b <= wv[7:0] & acs_pkg::AVG_MASK;
			end else if (wb_adr_i == acs_pkg::OFF_SAMP) begin
				samp_b <= wv[7:0] & acs_pkg::SAMP_MASK;
			end else if (wb_adr_i == acs_pkg::OFF_WINDOW_LOWER_THRESHOLD) begin
				window_lower_threshold_b <= wv[15:0];
			end else if (wb_adr_i == acs_pkg::OFF_WINDOW_UPPER_THRESHOLD) begin
				window_upper_threshold_b <= wv[15:0];
			end else if (wb_adr_i == acs_pkg::OFF_GAIN) begin
				gain_b <= wv[11:0];
			end else if (wb_adr_i == acs_pkg::OFF_OFFS) begin
				offs_b <= wv[11:0];
			end
		end
	end

	// Copies taken when the crossing completes
	always_ff @(posedge mclk) begin
		if (!reset_n || srst) begin
			en_c    <= 1'b0;
			control_third_reg_c <= acs_pkg::CONTROL_THIRD_REG_RST;
			samp_c  <= acs_pkg::SAMP_RST;
			insel_c <= 16'h0000;
		end else if (clk_en) begin
			if (sdone[acs_pkg::BSY_EN]) begin
				en_c <= en_b;
			end
			if (sdone[acs_pkg::BSY_CONTROL_THIRD_REG]) begin
				control_third_reg_c <= control_third_reg_b;
			end
			if (sdone[acs_pkg::BSY_SAMP]) begin
				samp_c <= samp_b;
			end
			if (sdone[acs_pkg::BSY_INSEL]) begin
				insel_c <= insel_b;
			end
		end
	end

	// Soft trigger pending until crossed
	always_ff @(posedge mclk) begin
		if (!reset_n || srst) begin
			trig_pend_r <= 1'b0;
		end else if (clk_en) begin
			if (wr && wb_adr_i == acs_pkg::OFF_TRIG) begin
				trig_pend_r <= wv[acs_pkg::TR_START];
			end else if (sdone[acs_pkg::BSY_TRIG]) begin
				trig_pend_r <= 1'b0;
			end
		end
	end

	// Result ready flag, write one to clear, set wins
	always_ff @(posedge mclk) begin
		if (!reset_n || srst) begin
			flag_r <= 1'b0;
		end else if (clk_en) begin
			if (done_r) begin
				flag_r <= 1'b1;
			end else if (wr && wb_adr_i == acs_pkg::OFF_FLAG &&
			             wv[acs_pkg::FL_RESULT_READY_FLAG]) begin
				flag_r <= 1'b0;
			end
		end
	end

	// Pin synchronizers
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			evt_s1 <= 1'b0;
			evt_s2 <= 1'b0;
			evt_s3 <= 1'b0;
			cmp_s1 <= 1'b0;
			cmp_s2 <= 1'b0;
		end else if (clk_en) begin
			evt_s1 <= event_start_i;
			evt_s2 <= evt_s1;
			evt_s3 <= evt_s2;
			cmp_s1 <= comp_i;
			cmp_s2 <= cmp_s1;
		end
	end

	// Start sources after synchronization
	assign trig_go  = sdone[acs_pkg::BSY_TRIG] & trig_pend_r;
	assign evt_go   = evt_s2 & ~evt_s3;
	assign start_go = en_c & (state_r == acs_pkg::ACS_IDLE) &
	                  (trig_go | evt_go);

	// Resolution and sampling settings
	always_comb begin
		case (control_third_reg_c[acs_pkg::CC_RES_LSB +: 2])
			acs_pkg::RES_10: res_bits = 4'd10;
			acs_pkg::RES_8:  res_bits = 4'd8;
			default:         res_bits = 4'd12;
		endcase
	end
	assign low_bit = 4'd12 - res_bits;
	assign offc    = samp_c[acs_pkg::SC_OFFSET_COMP_ENABLE];
	assign eff_len = offc ? 6'h00 : samp_c[5:0];

	// Prescaler, divide by two to one plus field
	assign div_top9 = (9'h002 << presc_r) - 9'h001;
	assign tick     = (div_r == div_top9[7:0]);
	assign first_half = ~div_r[presc_r];
	always_comb begin
		if (start_go || tick) begin
			div_nxt = 8'h00;
		end else begin
			div_nxt = div_r + 8'h01;
		end
	end
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			div_r     <= 8'h00;
			adc_clk_r <= 1'b0;
		end else if (clk_en) begin
			div_r     <= div_nxt;
			adc_clk_r <= ~div_nxt[presc_r];
		end
	end

	// Successive approximation step
	always_comb begin
		sar_dec = sar_r;
		if (!cmp_s2) begin
			sar_dec[bit_r] = 1'b0;
		end
		sar_nx = sar_dec | (12'h001 << (bit_r - 4'h1));
	end

	// Conversion sequence
	always_ff @(posedge mclk) begin
		if (!reset_n || srst) begin
			state_r <= acs_pkg::ACS_IDLE;
			cnt_r   <= 6'h00;
			sar_r   <= 12'h000;
			bit_r   <= 4'h0;
			res_r   <= 12'h000;
			done_r  <= 1'b0;
		end else if (clk_en) begin
			done_r <= 1'b0;
			if (!en_c) begin
				state_r <= acs_pkg::ACS_IDLE;
			end else begin
				case (state_r)
					acs_pkg::ACS_IDLE: begin
						if (start_go) begin
							state_r <= acs_pkg::ACS_SAMPLE;
							cnt_r <= eff_len;
							sar_r <= 12'h000;
						end
					end
					acs_pkg::ACS_SAMPLE: begin
						if (tick) begin
							if (cnt_r != 6'h00) begin
								cnt_r <= cnt_r - 6'h01;
							end else if (offc) begin
								state_r <= acs_pkg::ACS_OFFSET_COMP_ENABLE;
								cnt_r <= OC_LAST;
							end else begin
								state_r <= acs_pkg::ACS_CONV;
								sar_r <= 12'h800;
								bit_r <= 4'd11;
							end
						end
					end
					acs_pkg::ACS_OFFSET_COMP_ENABLE: begin
						if (tick) begin
							if (cnt_r != 6'h00) begin
								cnt_r <= cnt_r - 6'h01;
							end else begin
								state_r <= acs_pkg::ACS_CONV;
								sar_r <= 12'h800;
								bit_r <= 4'd11;
							end
						end
					end
					acs_pkg::ACS_CONV: begin
						if (tick) begin
							if (bit_r == low_bit) begin
								sar_r <= sar_dec;
								res_r <= sar_dec >> low_bit;
								done_r <= 1'b1;
								if (control_third_reg_c[acs_pkg::CC_FREE]) begin
									state_r <= acs_pkg::ACS_SAMPLE;
									cnt_r <= eff_len;
								end else begin
									state_r <= acs_pkg::ACS_IDLE;
								end
							end else begin
								sar_r <= sar_nx;
								bit_r <= bit_r - 4'h1;
							end
						end
					end
					default: state_r <= acs_pkg::ACS_IDLE;
				endcase
			end
		end
	end

	// Sample window and analog controls
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sample_r <= 1'b0;
		end else if (clk_en) begin
			sample_r <= (state_r == acs_pkg::ACS_SAMPLE) &&
			            (cnt_r != 6'h00 || eff_len != 6'h00 ||
			             first_half);
		end
	end

	assign wb_ack_o    = ack_r;
	assign wb_dat_o    = dat_r;
	assign adc_clk_o   = adc_clk_r;
	assign sample_o    = sample_r;
	assign diff_o      = control_third_reg_c[acs_pkg::CC_DIFF];
	assign dac_o       = sar_r;
	assign pos_sel_o   = insel_c[4:0];
	assign neg_sel_o   = insel_c[12:8];
	assign conv_done_o = done_r;

endmodule
`default_nettype wire

// file: tb/acs_adc_sequencer_monitor.sv
`default_nettype none
module acs_adc_sequencer_monitor #(
	parameter int OFFSET_COMP_ENABLE_CYCLES = acs_pkg::OFFSET_COMP_ENABLE_DEF,
	parameter int SYNC_CYCLES    = acs_pkg::SYNC_DEF
) (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        clk_en,
	// Register bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Converter side
	input wire logic        event_start_i,
	input wire logic        sample_o,
	input wire logic        diff_o,
	input wire logic [4:0]  pos_sel_o,
	input wire logic [4:0]  neg_sel_o,
	input wire logic        conv_done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cc_age_r;
	logic [3:0] mx_age_r;
	logic [3:0] tg_age_r;
	logic       ev_q_r;
	logic       tk;
	logic       srst;

	function automatic logic [3:0] inc(input logic [3:0] v);
		return (v == 4'hF) ? v : v + 4'h1;
	endfunction

	assign tk   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && clk_en;
	assign srst = (wb_adr_i == acs_pkg::OFF_CTRL_A) && wb_dat_i[0];

	// Ages since the last write, start edge or done that may move each output
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			cc_age_r <= 4'hF;
			mx_age_r <= 4'hF;
			tg_age_r <= 4'hF;
			ev_q_r   <= 1'b0;
		end else if (clk_en) begin
			ev_q_r   <= event_start_i;
			cc_age_r <= (tk && (wb_adr_i == acs_pkg::OFF_CTRL_C || srst))
				? 4'h0 : inc(cc_age_r);
			mx_age_r <= (tk && (wb_adr_i == acs_pkg::OFF_INSEL || srst))
				? 4'h0 : inc(mx_age_r);
			tg_age_r <= ((tk && wb_adr_i == acs_pkg::OFF_TRIG)
				|| (event_start_i && !ev_q_r) || conv_done_o)
				? 4'h0 : inc(tg_age_r);
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	AST_ACK_NEXT: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	AST_ACK_CAUSE: assert property (
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_ACK_PULSE: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_DAT_HOLD: assert property (
		!wb_ack_o |-> $stable(wb_dat_o))
		else $error("read data moved outside an access");
	AST_DONE_GAP: assert property (
		conv_done_o |=> !conv_done_o [*8])
		else $error("conversions too close together");
	AST_DIFF_SYNC: assert property (
		$changed(diff_o) |-> cc_age_r <= SYNC_CYCLES + 3)
		else $error("diff output moved without a control write");
	AST_MUX_SYNC: assert property (
		$changed({pos_sel_o, neg_sel_o}) |-> mx_age_r <= SYNC_CYCLES + 3)
		else $error("input select moved without a write");
	AST_START_CAUSE: assert property (
		$rose(sample_o) |-> tg_age_r <= SYNC_CYCLES + 6)
		else $error("sampling began without a start");
endmodule

bind acs_adc_sequencer acs_adc_sequencer_monitor #(
	.OFFSET_COMP_ENABLE_CYCLES(OFFSET_COMP_ENABLE_CYCLES),
	.SYNC_CYCLES   (SYNC_CYCLES)
) u_mon (
	.mclk         (mclk),
	.reset_n      (reset_n),
	.clk_en       (clk_en),
	.wb_cyc_i     (wb_cyc_i),
	.wb_stb_i     (wb_stb_i),
	.wb_we_i      (wb_we_i),
	.wb_adr_i     (wb_adr_i),
	.wb_dat_i     (wb_dat_i),
	.wb_dat_o     (wb_dat_o),
	.wb_ack_o     (wb_ack_o),
	.event_start_i(event_start_i),
	.sample_o     (sample_o),
	.diff_o       (diff_o),
	.pos_sel_o    (pos_sel_o),
	.neg_sel_o    (neg_sel_o),
	.conv_done_o  (conv_done_o)
);
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OC = acs_pkg::OFFSET_COMP_ENABLE_DEF;
	logic        mclk, reset_n, clk_en, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, d;
	logic        wb_ack_o, event_start_i, comp_i, adc_clk_o, a_q;
	logic        sample_o, diff_o, conv_done_o, oc;
	logic [11:0] dac_o, tgt;
	logic [4:0]  pos_sel_o, neg_sel_o;
	logic [1:0]  rc;
	int          n_mismatch, checks, seed, ac, a_per, sc, s_len, dc, d_gap;
	int          i, nb, per, sl;

	acs_adc_sequencer #(.SYNC_CYCLES(6)) dut (
		.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.event_start_i(event_start_i), .comp_i(comp_i),
		.adc_clk_o(adc_clk_o), .sample_o(sample_o), .diff_o(diff_o),
		.dac_o(dac_o), .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o),
		.conv_done_o(conv_done_o)
	);

	always #5 mclk = ~mclk;
	// Comparator: input at or above trial code
	always @(posedge mclk) comp_i <= (tgt >= dac_o);
	// Period, sampling and done-gap counters
	always @(posedge mclk) begin
		a_q <= adc_clk_o;
		ac <= (adc_clk_o && !a_q) ? 1 : ac + 1;
		if (adc_clk_o && !a_q) a_per <= ac;
		sc <= sample_o ? sc + 1 : 0;
		if (!sample_o && sc != 0) s_len <= sc;
		dc <= conv_done_o ? 1 : dc + 1;
		if (conv_done_o) d_gap <= dc;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chkc(input int g, input int e);
		checks++;
		if (g != e) begin
			n_mismatch++;
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] dt, output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= dt;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		q = wb_dat_o;
		if (n >= 40) chkc(n, 0);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dt);
		logic [31:0] q;
		bus(1'b1, a, dt, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (conv_done_o !== 1'b1 && n < 4000);
		if (n >= 4000) chkc(n, 0);
	endtask
	task automatic summarize;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge mclk);
		n_mismatch++;
		summarize();
	end

	initial begin
		mclk = 0; reset_n = 0; clk_en = 1; wb_cyc_i = 0; wb_stb_i = 0;
		wb_we_i = 0; wb_adr_i = 0; wb_sel_i = 4'hF; wb_dat_i = 0;
		event_start_i = 0; comp_i = 0; tgt = 0; a_q = 0; seed = 32'h6878;
		n_mismatch = 0; checks = 0; ac = 0; sc = 0; dc = 0;
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		rd(acs_pkg::OFF_BUSY, 32'h0);
		rd(acs_pkg::OFF_CTRL_C, {24'h0, acs_pkg::CONTROL_THIRD_REG_RST});
		rd(8'hFC, 32'h0);
		rd(acs_pkg::OFF_TRIG, 32'h0);
		d = $random(seed);
		wr(acs_pkg::OFF_CTRL_C, d);
		rd(acs_pkg::OFF_CTRL_C, {24'h0, d[7:0] & acs_pkg::CONTROL_THIRD_REG_MASK});
		// Offsets 08..28 in busy-bit order, then soft reset
		for (i = 0; i < 10; i++) begin
			wr(i == 9 ? acs_pkg::OFF_CTRL_A : 8'(8 + 4 * i), 32'(i == 9));
			rd(acs_pkg::OFF_BUSY, i == 9 ? 32'h3 : 32'h1 << (2 + i));
		end
		// Clock enable low freezes a crossing in flight
		wr(acs_pkg::OFF_CTRL_C, 32'h0);
		clk_en <= 1'b0;
		repeat (20) @(posedge mclk);
		clk_en <= 1'b1;
		rd(acs_pkg::OFF_BUSY, 32'h1 << acs_pkg::BSY_CONTROL_THIRD_REG);
		repeat (20) @(posedge mclk);
		rd(acs_pkg::OFF_BUSY, 32'h0);
		rd(acs_pkg::OFF_CTRL_C, {24'h0, acs_pkg::CONTROL_THIRD_REG_RST});
		for (i = 0; i < 6; i++) begin
			rc = (i % 3 == 0) ? acs_pkg::RES_12
				: (i % 3 == 1) ? acs_pkg::RES_10 : acs_pkg::RES_8;
			nb = 12 - 2 * (i % 3);
			per = 4 << (i % 2);
			d = $random(seed);
			oc = d[0];
			sl = oc ? 0 : int'(d[2:1]);
			tgt <= d[15:4];
			wr(acs_pkg::OFF_CTRL_B, 32'(1 + i % 2));
			wr(acs_pkg::OFF_SAMP, {24'h0, oc, 1'b0, 6'(sl)});
			wr(acs_pkg::OFF_CTRL_C, {26'h0, rc, 3'h0, i[0]});
			wr(acs_pkg::OFF_INSEL, {19'h0, 5'(i + 1), 3'h0, 5'(i)});
			wr(acs_pkg::OFF_CTRL_A, 32'h2);
			repeat (12) @(posedge mclk);
			if (i % 2 == 0) begin
				wr(acs_pkg::OFF_TRIG, 32'h2);
			end else begin
				event_start_i <= 1'b1;
				repeat (4) @(posedge mclk);
				event_start_i <= 1'b0;
			end
			wait_done();
			chk({31'h0, diff_o}, {31'h0, i[0]});
			chk({22'h0, neg_sel_o, pos_sel_o}, {22'h0, 5'(i + 1), 5'(i)});
			chk({20'h0, dac_o}, ({20'h0, tgt} >> (12 - nb)) << (12 - nb));
			chkc(a_per, per);
			if (!oc) chkc(s_len, sl == 0 ? per / 2 : (sl + 1) * per);
			rd(acs_pkg::OFF_FLAG, 32'h1);
			rd(acs_pkg::OFF_RESULT, {20'h0, tgt} >> (12 - nb));
			wr(acs_pkg::OFF_FLAG, 32'h1);
			rd(acs_pkg::OFF_FLAG, 32'h0);
			wr(acs_pkg::OFF_CTRL_C, {26'h0, rc, 3'h2, i[0]});
			repeat (10) @(posedge mclk);
			wr(acs_pkg::OFF_TRIG, 32'h2);
			wait_done();
			wait_done();
			wait_done();
			chkc(d_gap, (sl + 1 + (oc ? OC : 0) + nb) * per);
			rd(acs_pkg::OFF_FLAG, 32'h1);
			wr(acs_pkg::OFF_CTRL_A, 32'h0);
			repeat (20) @(posedge mclk);
			wr(acs_pkg::OFF_FLAG, 32'h1);
		end
		summarize();
	end
endmodule
`default_nettype wire
